// File: plmd_pkg.sv
// Package of constants for the port 0 latch, match and drive block
package plmd_pkg;

  // ----------------------------------------------------------------
  // Special-function addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PLMD_ADDR_LATCH = 8'h80;  // Port 0 output latch
  localparam logic [7:0] PLMD_ADDR_DRIVE = 8'hF6;  // Drive strength
  localparam logic [7:0] PLMD_ADDR_MATCH = 8'hFD;  // Port 0 match value
  localparam logic [7:0] PLMD_ADDR_MASK  = 8'hFE;  // Port 0 compare mask

  // ----------------------------------------------------------------
  // Bit-space addresses of the latch bits: base plus bit index
  // ----------------------------------------------------------------
  localparam logic [7:0] PLMD_BIT_BASE   = 8'h80;
  localparam logic [4:0] PLMD_BIT_PAGE   = 5'h10;  // Upper five bits of the bit space

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] PLMD_RST_LATCH  = 8'hFF;
  localparam logic [7:0] PLMD_RST_MATCH  = 8'hFF;
  localparam logic [7:0] PLMD_RST_MASK   = 8'h00;
  localparam logic [2:0] PLMD_RST_DRIVE  = 3'h7;   // All ports high drive
  localparam logic [4:0] PLMD_DRV_RSVD   = 5'h00;  // Reserved bits 7:3 read value
  localparam int         PLMD_DRV_P0_POS = 0;
  localparam int         PLMD_DRV_P1_POS = 1;
  localparam int         PLMD_DRV_P2_POS = 2;

  // ----------------------------------------------------------------
  // Compare stage states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PLMD_CMP_IDLE  = 2'b00,  // Nothing compared
    PLMD_CMP_MATCH = 2'b01,  // All compared pins equal
    PLMD_CMP_MISS  = 2'b11   // At least one mismatch
  } plmd_cmp_e;

endpackage

// File: plmd_match.sv
// Mask and match comparator for port 0 pins
`timescale 1ns/100ps

module plmd_match
  import plmd_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Compare operands
  input  wire logic [WIDTH-1:0] pin_level,
  input  wire logic [WIDTH-1:0] port0_compare_mask,
  input  wire logic [WIDTH-1:0] port0_match_value,
  // Result
  output logic                  port_mismatch
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("plmd_match: WIDTH must be 1 to 8");
  end

  plmd_cmp_e state;       // Compare state
  plmd_cmp_e next_state;  // Next compare state

  // ----------------------------------------------------------------
  // Compare logic
  // ----------------------------------------------------------------
  // Only unmasked pins take part; masked pins can never flag a miss
  always_comb
  begin
    if (|((pin_level ^ port0_match_value) & port0_compare_mask))
      next_state = PLMD_CMP_MISS;
    else if (|port0_compare_mask)
      next_state = PLMD_CMP_MATCH;
    else
      next_state = PLMD_CMP_IDLE;
  end

  // Register the state so the event leaves a flop
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= PLMD_CMP_IDLE;
    else
      state <= next_state;
  end

  // Event follows the state one cycle after the pins; the top state bit is
  // set only in the miss state, so the event leaves the flop with no decode
  assign port_mismatch = state[1];

endmodule // plmd_match

// File: plmd_port0.sv
// Port 0 latch, mask/match compare and port drive-strength select
//
// Functional notes
// - Drive bit per port: 0 low, 1 high
// - All drive bits reset to high drive
// - Mask 0 excludes pin from comparison
// - Mask 1 compares pin with match bit
// - Match bit gives expected pin level
// - Latch write sets digital output value
// - Latch read returns actual pin levels
// - Latch 0 drives low, 1 high/float
// - Latch supports bit and byte access
// - Analog pins: pullup, driver, receiver off
`timescale 1ns/100ps

module plmd_port0
  import plmd_pkg::*;
#(
  parameter int WIDTH = 8  // Pins on port 0
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Special-function byte access
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic             sfr_rd,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  // Bit access (bit-space address)
  input  wire logic [7:0]       bit_addr,
  input  wire logic             bit_wr,
  input  wire logic             bit_rd,
  input  wire logic             bit_wdata,
  output logic                  bit_rdata,
  // Pin configuration from the mode registers
  input  wire logic [WIDTH-1:0] pin_digital,
  input  wire logic [WIDTH-1:0] pin_push_pull,
  input  wire logic             weak_pullup_off,
  // Port 0 pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] pin_pullup_en,
  output logic      [WIDTH-1:0] pin_rx_en,
  // Drive strength outputs to the three ports
  output logic                  port0_drive_select,
  output logic                  port1_drive_select,
  output logic                  port2_drive_select,
  // Event
  output logic                  port_mismatch
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("plmd_port0: WIDTH must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] port0_output_latch;       // Output latch
  logic [WIDTH-1:0] next_port0_output_latch;
  logic [WIDTH-1:0] port0_match_value;        // Expected levels
  logic [WIDTH-1:0] next_port0_match_value;
  logic [WIDTH-1:0] port0_compare_mask;       // Compare enables
  logic [WIDTH-1:0] next_port0_compare_mask;
  logic [2:0]       drive_sel;                // Drive strength bits
  logic [2:0]       next_drive_sel;
  logic [7:0]       next_sfr_rdata;
  logic             next_bit_rdata;
  logic [WIDTH-1:0] pin_seen;                 // Level as the receiver sees it
  logic [WIDTH-1:0] next_pin_out;
  logic [WIDTH-1:0] next_pin_oe_n;
  logic [WIDTH-1:0] next_pin_pullup_en;
  logic [WIDTH-1:0] next_pin_rx_en;

  // Widen a port-wide vector to a byte, upper bits zero
  function automatic logic [7:0] to_byte(input logic [WIDTH-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[WIDTH-1:0] = v;
    return b;
  endfunction

  // True when a bit-space address hits a latch bit
  function automatic logic bit_hit(input logic [7:0] a);
    return (a[7:3] == PLMD_BIT_PAGE) && (32'(a[2:0]) < WIDTH);
  endfunction

  // Analog pins read as zero since their receiver is off
  assign pin_seen = pin_in & pin_digital;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_port0_output_latch = port0_output_latch;
    next_port0_match_value  = port0_match_value;
    next_port0_compare_mask = port0_compare_mask;
    next_drive_sel          = drive_sel;
    // Byte writes
    if (sfr_wr)
    begin
      if (sfr_addr == PLMD_ADDR_LATCH)
        next_port0_output_latch = sfr_wdata[WIDTH-1:0];
      else if (sfr_addr == PLMD_ADDR_DRIVE)
        next_drive_sel = sfr_wdata[2:0];  // reserved bits are not stored
      else if (sfr_addr == PLMD_ADDR_MATCH)
        next_port0_match_value = sfr_wdata[WIDTH-1:0];
      else if (sfr_addr == PLMD_ADDR_MASK)
        next_port0_compare_mask = sfr_wdata[WIDTH-1:0];
    end
    // Bit write touches one latch bit only
    if (bit_wr && bit_hit(bit_addr))
      next_port0_output_latch[bit_addr[2:0]] = bit_wdata;
  end

  // Registers only; reset sets documented values
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      port0_output_latch <= PLMD_RST_LATCH[WIDTH-1:0];
      port0_match_value  <= PLMD_RST_MATCH[WIDTH-1:0];
      port0_compare_mask <= PLMD_RST_MASK[WIDTH-1:0];
      drive_sel          <= PLMD_RST_DRIVE;
    end
    else
    begin
      port0_output_latch <= next_port0_output_latch;
      port0_match_value  <= next_port0_match_value;
      port0_compare_mask <= next_port0_compare_mask;
      drive_sel          <= next_drive_sel;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Latch reads return pin levels, not the latch; held while idle
  always_comb
  begin
    next_sfr_rdata = sfr_rdata;
    next_bit_rdata = bit_rdata;
    if (sfr_rd)
    begin
      if (sfr_addr == PLMD_ADDR_LATCH)
        next_sfr_rdata = to_byte(pin_seen);
      else if (sfr_addr == PLMD_ADDR_DRIVE)
        next_sfr_rdata = {PLMD_DRV_RSVD, drive_sel};
      else if (sfr_addr == PLMD_ADDR_MATCH)
        next_sfr_rdata = to_byte(port0_match_value);
      else if (sfr_addr == PLMD_ADDR_MASK)
        next_sfr_rdata = to_byte(port0_compare_mask);
      else
        next_sfr_rdata = 8'h00;  // Not ours: answer zero
    end
    if (bit_rd)
      next_bit_rdata = bit_hit(bit_addr) ? pin_seen[bit_addr[2:0]] : 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sfr_rdata <= 8'h00;
      bit_rdata <= 1'b0;
    end
    else
    begin
      sfr_rdata <= next_sfr_rdata;
      bit_rdata <= next_bit_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // A 1 in open-drain mode releases the pin so the pullup floats it high
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_pin_out[i]       = port0_output_latch[i];
      next_pin_oe_n[i]      = ~(pin_digital[i] &
                                (~port0_output_latch[i] | pin_push_pull[i]));
      next_pin_pullup_en[i] = pin_digital[i] & ~weak_pullup_off;
      next_pin_rx_en[i]     = pin_digital[i];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_out       <= PLMD_RST_LATCH[WIDTH-1:0];
      pin_oe_n      <= '1;  // Released during reset
      pin_pullup_en <= '0;
      pin_rx_en     <= '0;
    end
    else
    begin
      pin_out       <= next_pin_out;
      pin_oe_n      <= next_pin_oe_n;
      pin_pullup_en <= next_pin_pullup_en;
      pin_rx_en     <= next_pin_rx_en;
    end
  end

  // Drive selects come straight from the register flops
  assign port0_drive_select = drive_sel[PLMD_DRV_P0_POS];
  assign port1_drive_select = drive_sel[PLMD_DRV_P1_POS];
  assign port2_drive_select = drive_sel[PLMD_DRV_P2_POS];

  // ----------------------------------------------------------------
  // Mismatch compare
  // ----------------------------------------------------------------
  plmd_match #(
    .WIDTH (WIDTH)
  ) u_match (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .pin_level          (pin_seen),
    .port0_compare_mask (port0_compare_mask),
    .port0_match_value  (port0_match_value),
    .port_mismatch      (port_mismatch)
  );

endmodule // plmd_port0

// File: plmd_monitor.sv
// Checker of port timing for the port 0 latch, match and drive block
`timescale 1ns/100ps
module plmd_monitor
  import plmd_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock, reset and register access
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic [7:0]       sfr_addr,
  input wire logic             sfr_wr,
  input wire logic             sfr_rd,
  input wire logic [7:0]       sfr_wdata,
  input wire logic [7:0]       sfr_rdata,
  input wire logic [7:0]       bit_addr,
  input wire logic             bit_wr,
  input wire logic             bit_rd,
  input wire logic             bit_rdata,
  // Pins and outputs
  input wire logic [WIDTH-1:0] pin_digital,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe_n,
  input wire logic [WIDTH-1:0] pin_pullup_en,
  input wire logic [WIDTH-1:0] pin_rx_en,
  input wire logic             port0_drive_select,
  input wire logic             port1_drive_select,
  input wire logic             port2_drive_select,
  input wire logic             port_mismatch
);
  // ----
  // Shadow of mask and match, so the event can be judged
  // ----
  logic [7:0] sh_mask;   // Mask as last written
  logic [7:0] sh_match;  // Match as last written
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sh_mask  <= PLMD_RST_MASK;
      sh_match <= PLMD_RST_MATCH;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == PLMD_ADDR_MASK) sh_mask <= sfr_wdata;
      if (sfr_addr == PLMD_ADDR_MATCH) sh_match <= sfr_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // A write, then a cycle with no byte write at all (and, for the latch, no bit write)
  sequence s_drv_wr; sfr_wr && sfr_addr == PLMD_ADDR_DRIVE ##1 !sfr_wr; endsequence
  sequence s_lat_wr; sfr_wr && sfr_addr == PLMD_ADDR_LATCH && !bit_wr ##1 !sfr_wr && !bit_wr;
  endsequence
  property p_rd_pins; sfr_rd && sfr_addr == PLMD_ADDR_LATCH
    |=> sfr_rdata == $past(pin_in & pin_digital); endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("latch read not pin level");
  property p_drv_upd; s_drv_wr |=> {port2_drive_select, port1_drive_select,
    port0_drive_select} == $past(sfr_wdata[2:0], 2); endproperty
  a_drv_upd: assert property (p_drv_upd) else $error("drive select not written");
  property p_drv_rst; disable iff (1'b0) sys_rst |=> port0_drive_select
    && port1_drive_select && port2_drive_select && !port_mismatch; endproperty
  a_drv_rst: assert property (p_drv_rst) else $error("reset drive not high");
  property p_mask_off; sfr_wr && sfr_addr == PLMD_ADDR_MASK && sfr_wdata == 8'h00
    ##1 !sfr_wr |=> !port_mismatch; endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked pins raised event");
  property p_miss; port_mismatch == |($past(sh_mask)
    & ($past(pin_in & pin_digital) ^ $past(sh_match))); endproperty
  a_miss: assert property (p_miss) else $error("mismatch event wrong");
  property p_latch_out; s_lat_wr |=> pin_out == $past(sfr_wdata, 2); endproperty
  a_latch_out: assert property (p_latch_out) else $error("latch not on pins");
  property p_drive_lo; (~pin_out & $past(pin_digital) & pin_oe_n) == '0; endproperty
  a_drive_lo: assert property (p_drive_lo) else $error("latch zero not driven");
  property p_analog; ($past(~pin_digital)
    & (~pin_oe_n | pin_pullup_en | pin_rx_en)) == '0; endproperty
  a_analog: assert property (p_analog) else $error("analog pin not isolated");
  property p_bit_rd; bit_rd && bit_addr[7:3] == PLMD_BIT_PAGE |=> bit_rdata
    == $past(pin_in[bit_addr[2:0]] & pin_digital[bit_addr[2:0]]); endproperty
  a_bit_rd: assert property (p_bit_rd) else $error("bit read not pin level");
endmodule // plmd_monitor
bind plmd_port0 plmd_monitor #(.WIDTH(WIDTH)) u_mon (.clk_sys, .sys_rst, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .bit_addr, .bit_wr, .bit_rd, .bit_rdata,
  .pin_digital, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_rx_en,
  .port0_drive_select, .port1_drive_select, .port2_drive_select, .port_mismatch);

// File: plmd_pins.sv
// Model of the outside circuitry on the port 0 pins
`timescale 1ns/100ps
module plmd_pins #(parameter int WIDTH = 8)
(
  // Clock and pad drive from the port
  input  wire logic             clk_sys,
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe_n,
  input  wire logic [WIDTH-1:0] pin_pullup_en,
  // Outside driver and resolved level
  input  wire logic [WIDTH-1:0] ext_en,
  input  wire logic [WIDTH-1:0] ext_val,
  output logic      [WIDTH-1:0] pin_in
);
  logic [WIDTH-1:0] wander = '0;  // Undriven pins never keep a stale level
  always @(posedge clk_sys) wander <= ~wander;
  // Pad wins, then the outside driver, then the pullup or the wander
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pullup_en | wander));
endmodule // plmd_pins

// File: testbench.sv
// Self-checking bench for the port 0 latch, match and drive block
`timescale 1ns/100ps
module testbench;
  import plmd_pkg::*;
  // ----
  // Stimulus and observed signals
  // ----
  logic       clk_sys = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_rd = 0;
  logic       bit_wdata = 0, wpu_off = 0, bit_rdata, port_mismatch;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, bit_addr = 0, sfr_rdata, lat, v, m, t;
  logic [7:0] dig = 8'hff, pp = 8'hff, ext_en = 8'hff, ext_val = 0;
  logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_rx_en;
  wire  [2:0] drv;  // Drive selects, port 2 down to port 0; one port drives each bit
  int         mismatches = 0, samples_checked = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  plmd_port0 #(.WIDTH(8)) uut (.clk_sys, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .bit_rdata, .pin_digital(dig),
    .pin_push_pull(pp), .weak_pullup_off(wpu_off), .pin_in, .pin_out, .pin_oe_n,
    .pin_pullup_en, .pin_rx_en, .port0_drive_select(drv[0]), .port1_drive_select(drv[1]),
    .port2_drive_select(drv[2]), .port_mismatch);
  plmd_pins #(.WIDTH(8)) u_pins (.clk_sys, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_en,
    .ext_val, .pin_in);
  // Pin level as the port reads it: open-drain ones are pulled by the outside
  function automatic logic [7:0] lvl(input logic [7:0] l, input logic [7:0] e);
    return l & (pp | e) & dig;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Byte write, held one edge, returns once pins have followed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    {sfr_addr, sfr_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask
  task automatic bit_op(input logic [7:0] a, input logic w, input logic d, input logic e);
    @(posedge clk_sys);
    {bit_addr, bit_wdata, bit_wr, bit_rd} <= {a, d, w, !w};
    @(posedge clk_sys);
    {bit_wr, bit_rd} <= 2'b00;
    @(posedge clk_sys);
    #1 if (!w) chk({7'h00, bit_rdata}, {7'h00, e});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well above the fewer than 600 cycles of the run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(37));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk({5'h00, drv}, {5'h00, PLMD_RST_DRIVE});
    rd(PLMD_ADDR_DRIVE, {PLMD_DRV_RSVD, PLMD_RST_DRIVE});
    rd(PLMD_ADDR_MATCH, PLMD_RST_MATCH);
    rd(PLMD_ADDR_MASK, PLMD_RST_MASK);
    rd(PLMD_ADDR_LATCH, lvl(PLMD_RST_LATCH, ext_val));
    rd(8'h81, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr(PLMD_ADDR_DRIVE, {PLMD_DRV_RSVD, 3'(i)});
      chk({5'h00, drv}, 8'(i));
      rd(PLMD_ADDR_DRIVE, 8'(i));
    end
    $display("test drive done");
    for (int i = 0; i < 12; i++)
    begin
      lat = (i == 0) ? 8'h00 : 8'($urandom);
      @(posedge clk_sys);
      ext_val <= 8'($urandom);
      pp      <= (i < 4) ? 8'hff : 8'($urandom);
      dig     <= (i < 8) ? 8'hff : 8'($urandom);
      wpu_off <= 1'($urandom);
      wr(PLMD_ADDR_LATCH, lat);
      chk(pin_out, lat);
      chk(pin_rx_en, dig);
      chk(pin_pullup_en, dig & {8{~wpu_off}});
      rd(PLMD_ADDR_LATCH, lvl(lat, ext_val));
    end
    // Bit writes keep the model in step; the ninth is out of range and must be ignored
    for (int n = 0; n < 9; n++)
    begin
      if (n < 8)
        lat[n] = 1'($urandom);
      bit_op(PLMD_BIT_BASE + 8'(n), 1'b1, lat[n%8] ^ (n == 8), 1'b0);
      chk(pin_out, lat);
      v = lvl(lat, ext_val);
      bit_op(PLMD_BIT_BASE + 8'(n), 1'b0, 1'b0, (n < 8) ? v[n%8] : 1'b0);
    end
    $display("test latch done");
    for (int i = 0; i < 40; i++)
    begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      t = 8'($urandom);
      wr(PLMD_ADDR_MASK, m);
      wr(PLMD_ADDR_MATCH, t);
      @(posedge clk_sys);
      ext_val <= (i == 1) ? t : 8'($urandom);
      dig     <= (i < 2) ? 8'hff : 8'($urandom);
      pp      <= 8'h00;
      repeat (3) @(posedge clk_sys);
      #1 chk({7'h00, port_mismatch}, {7'h00, |(m & (lvl(lat, ext_val) ^ t))});
    end
    $display("test mismatch done");
    // Reset in mid-run: drive bits cleared first so the return to high drive shows
    wr(PLMD_ADDR_DRIVE, 8'h00);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk({5'h00, drv}, {5'h00, PLMD_RST_DRIVE});
    @(posedge clk_sys);
    #1 chk(pin_out, PLMD_RST_LATCH);
    rd(PLMD_ADDR_MASK, PLMD_RST_MASK);
    chk({7'h00, port_mismatch}, 8'h00);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule // testbench
